// ===== include/irq_pkg.sv
package irq_pkg;

    // ==========================================================
    // Bus shape
    // ==========================================================
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;
    localparam int PORT_W = 8;

    // ==========================================================
    // Register byte offsets
    // ==========================================================
    localparam logic [ADDR_W-1:0] OFS_INTERRUPT_CONTROL = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_PERIPHERAL_IRQ_ENABLE_1 = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_EDGE_CONFIG = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_PIN_CHANGE_CONFIG = 12'h00C;
    localparam logic [ADDR_W-1:0] OFS_PERIPH_FLAG_STATUS = 12'h010;

    // ==========================================================
    // Field positions in interrupt_control and the edge register
    // ==========================================================
    localparam int BIT_GLOBAL_IRQ_ENABLE = 7;
    localparam int BIT_PERIPHERAL_GROUP_ENABLE = 6;
    localparam int BIT_TIMER0_OVERFLOW_ENABLE = 5;
    localparam int BIT_EXT_PIN_IRQ_ENABLE = 4;
    localparam int BIT_PORT_CHANGE_ENABLE = 3;
    localparam int BIT_TIMER0_OVERFLOW_FLAG = 2;
    localparam int BIT_EXT_PIN_IRQ_FLAG = 1;
    localparam int BIT_PORT_CHANGE_FLAG = 0;
    localparam int BIT_EDGE_RISING = 0;

    // ==========================================================
    // Values after reset
    // ==========================================================
    localparam logic [REG_W-1:0] RST_INTERRUPT_CONTROL = 8'h00;
    localparam logic [REG_W-1:0] RST_PERIPHERAL_IRQ_ENABLE_1 = 8'h00;
    localparam logic RST_EDGE_RISING = 1'b1;
    localparam logic [PORT_W-1:0] RST_PIN_CHANGE_CONFIG = 8'h00;
    localparam logic [DATA_W-1:0] RST_PRDATA = 32'h0000_0000;

    // ==========================================================
    // Carriers
    // ==========================================================
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [DATA_W-1:0] prdata;
    } apb_rsp_t;

    typedef enum {
        REG_CONTROL,
        REG_PERIPHERAL_IRQ_ENABLE_1,
        REG_EDGE,
        REG_PIN_CFG,
        REG_PFLAGS,
        REG_NONE
    } reg_sel_t;

endpackage

// ===== rtl/core_interrupt_enable_logic.sv
// Overview of operation
// - Global enable set passes unmasked requests; cleared forwards no request.
// - Peripheral group enable set permits peripheral sources; cleared blocks them.
// - Sources enabled in peripheral enable register need peripheral group enable.
// - Timer0 overflow enable gates timer0 overflow flag into request.
// - External pin enable gates external edge flag into request.
// - Port change enable gates port change flag into request.
// - Timer0 overflow sets flag; a software write of zero or a reset clears it.
// - External pin event sets flag; software or a reset clears it.
// - Any enabled port pin change sets flag; software or a reset clears it.
// - Timer1 gate enable gates timer1 gate event into peripheral request.
// - Converter enable gates conversion-complete event into peripheral request.
// - Serial receive enable gates receive-buffer-full event into peripheral request.
// - Serial transmit enable gates transmit-buffer-empty event into peripheral request.
// - Sync serial enable gates transfer-complete event into peripheral request.
// - Capture/compare one enable gates its event into peripheral request.
// - Timer2 match enable gates timer2 period match into peripheral request.
// - Timer1 overflow enable gates timer1 overflow into peripheral request.
// - Flags set on events regardless of any enable bit.
// - Every reset clears global, group and all individual enables.
`timescale 1ns/1ps
`default_nettype none

module core_interrupt_enable_logic
    import irq_pkg::*;
#(
    parameter int PORT_PINS = PORT_W
)
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,

    // APB slave
    input wire apb_req_t apb_i,
    output apb_rsp_t apb_o,

    // Event sources
    input wire logic timer0_overflow_i,
    input wire logic external_irq_pin_i,
    input wire logic [PORT_PINS-1:0] general_port_i,
    input wire logic [REG_W-1:0] periph_flags_i,

    // To CPU sequencer
    output logic irq_o
);

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        logic global_irq_enable;
        logic peripheral_group_enable;
        logic timer0_overflow_enable;
        logic ext_pin_irq_enable;
        logic port_change_enable;
        logic timer0_overflow_flag;
        logic ext_pin_irq_flag;
        logic port_change_flag;
        logic [REG_W-1:0] peripheral_irq_enable_1;
        logic edge_rising;
        logic [PORT_PINS-1:0] pin_change_config;
        logic ext_meta;
        logic ext_sync;
        logic ext_prev;
        logic [PORT_PINS-1:0] port_meta;
        logic [PORT_PINS-1:0] port_sync;
        logic [PORT_PINS-1:0] port_prev;
        apb_rsp_t rsp;
        logic irq;
    } state_t;

    state_t state_q;
    state_t state_d;

    // ==========================================================
    // Address decode
    // ==========================================================
    function automatic reg_sel_t decode(input logic [ADDR_W-1:0] addr);
        reg_sel_t sel;
        if (addr == OFS_INTERRUPT_CONTROL)
        begin
            sel = REG_CONTROL;
        end
        else if (addr == OFS_PERIPHERAL_IRQ_ENABLE_1)
        begin
            sel = REG_PERIPHERAL_IRQ_ENABLE_1;
        end
        else if (addr == OFS_EDGE_CONFIG)
        begin
            sel = REG_EDGE;
        end
        else if (addr == OFS_PIN_CHANGE_CONFIG)
        begin
            sel = REG_PIN_CFG;
        end
        else if (addr == OFS_PERIPH_FLAG_STATUS)
        begin
            sel = REG_PFLAGS;
        end
        else
        begin
            sel = REG_NONE;
        end
        return sel;
    endfunction

    // ==========================================================
    // Per-pin change detect
    // ==========================================================
    logic [PORT_PINS-1:0] pin_changed;

    for (genvar i = 0; i < PORT_PINS; i++)
    begin : g_pin
        // Pins left out of the config never raise the flag
        assign pin_changed[i] = state_q.pin_change_config[i]
            & (state_q.port_sync[i] ^ state_q.port_prev[i]);
    end

    // ==========================================================
    // Combinational view of registers
    // ==========================================================
    logic [REG_W-1:0] control_view;
    logic [REG_W-1:0] pie_view;
    logic [REG_W-1:0] wbyte;
    logic setup;
    logic access;
    logic wr;
    logic ext_edge;
    logic core_req;
    logic periph_req;
    reg_sel_t setup_sel;
    reg_sel_t access_sel;

    always_comb
    begin
        control_view = '0;
        control_view[BIT_GLOBAL_IRQ_ENABLE] = state_q.global_irq_enable;
        control_view[BIT_PERIPHERAL_GROUP_ENABLE] = state_q.peripheral_group_enable;
        control_view[BIT_TIMER0_OVERFLOW_ENABLE] = state_q.timer0_overflow_enable;
        control_view[BIT_EXT_PIN_IRQ_ENABLE] = state_q.ext_pin_irq_enable;
        control_view[BIT_PORT_CHANGE_ENABLE] = state_q.port_change_enable;
        control_view[BIT_TIMER0_OVERFLOW_FLAG] = state_q.timer0_overflow_flag;
        control_view[BIT_EXT_PIN_IRQ_FLAG] = state_q.ext_pin_irq_flag;
        control_view[BIT_PORT_CHANGE_FLAG] = state_q.port_change_flag;
        pie_view = state_q.peripheral_irq_enable_1;
    end

    assign setup = apb_i.psel & ~apb_i.penable;
    assign access = apb_i.psel & apb_i.penable & state_q.rsp.pready;
    assign wr = access & apb_i.pwrite;
    assign wbyte = apb_i.pwdata[REG_W-1:0];
    assign setup_sel = decode(apb_i.paddr);
    assign access_sel = decode(apb_i.paddr);

    // Edge polarity chosen by software
    assign ext_edge = state_q.edge_rising
        ? (state_q.ext_sync & ~state_q.ext_prev)
        : (~state_q.ext_sync & state_q.ext_prev);

    // ==========================================================
    // Request combine
    // ==========================================================
    always_comb
    begin
        core_req = (state_q.timer0_overflow_enable & state_q.timer0_overflow_flag)
            | (state_q.ext_pin_irq_enable & state_q.ext_pin_irq_flag)
            | (state_q.port_change_enable & state_q.port_change_flag);
        // Bit order matches the enable register: 7 gate .. 0 timer1 overflow
        periph_req = |(state_q.peripheral_irq_enable_1 & periph_flags_i)
            ;
    end

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb
    begin
        state_d = state_q;

        // Two-stage synchronisers, then one stage for edge history
        state_d.ext_meta = external_irq_pin_i;
        state_d.ext_sync = state_q.ext_meta;
        state_d.ext_prev = state_q.ext_sync;
        state_d.port_meta = general_port_i;
        state_d.port_sync = state_q.port_meta;
        state_d.port_prev = state_q.port_sync;

        // Software writes land first so hardware sets can win below
        if (wr && access_sel == REG_CONTROL)
        begin
            state_d.global_irq_enable = wbyte[BIT_GLOBAL_IRQ_ENABLE];
            state_d.peripheral_group_enable = wbyte[BIT_PERIPHERAL_GROUP_ENABLE];
            state_d.timer0_overflow_enable = wbyte[BIT_TIMER0_OVERFLOW_ENABLE];
            state_d.ext_pin_irq_enable = wbyte[BIT_EXT_PIN_IRQ_ENABLE];
            state_d.port_change_enable = wbyte[BIT_PORT_CHANGE_ENABLE];
            state_d.timer0_overflow_flag = wbyte[BIT_TIMER0_OVERFLOW_FLAG];
            state_d.ext_pin_irq_flag = wbyte[BIT_EXT_PIN_IRQ_FLAG];
            state_d.port_change_flag = wbyte[BIT_PORT_CHANGE_FLAG];
        end
        else if (wr && access_sel == REG_PERIPHERAL_IRQ_ENABLE_1)
        begin
            state_d.peripheral_irq_enable_1 = wbyte;
        end
        else if (wr && access_sel == REG_EDGE)
        begin
            state_d.edge_rising = wbyte[BIT_EDGE_RISING];
        end
        else if (wr && access_sel == REG_PIN_CFG)
        begin
            state_d.pin_change_config = wbyte[PORT_PINS-1:0];
        end

        // Flags ignore every enable, and an event beats a clearing write
        if (timer0_overflow_i)
        begin
            state_d.timer0_overflow_flag = 1'b1;
        end
        if (ext_edge)
        begin
            state_d.ext_pin_irq_flag = 1'b1;
        end
        if (|pin_changed)
        begin
            state_d.port_change_flag = 1'b1;
        end

        // Zero-wait slave: answer sits ready for the first access cycle
        state_d.rsp.pready = setup;
        state_d.rsp.pslverr = 1'b0;
        state_d.rsp.prdata = RST_PRDATA;
        if (setup)
        begin
            if (setup_sel == REG_CONTROL)
            begin
                state_d.rsp.prdata[REG_W-1:0] = control_view;
            end
            else if (setup_sel == REG_PERIPHERAL_IRQ_ENABLE_1)
            begin
                state_d.rsp.prdata[REG_W-1:0] = pie_view;
            end
            else if (setup_sel == REG_EDGE)
            begin
                state_d.rsp.prdata[BIT_EDGE_RISING] = state_q.edge_rising;
            end
            else if (setup_sel == REG_PIN_CFG)
            begin
                state_d.rsp.prdata[PORT_PINS-1:0] = state_q.pin_change_config;
            end
            else if (setup_sel == REG_PFLAGS)
            begin
                state_d.rsp.prdata[REG_W-1:0] = periph_flags_i;
            end
            else
            begin
                state_d.rsp.pslverr = 1'b1;
            end
        end

        // Registered request: one cycle behind the flags it reflects
        state_d.irq = state_q.global_irq_enable
            & (core_req
            | (state_q.peripheral_group_enable & periph_req));
    end

    // ==========================================================
    // Registers
    // ==========================================================
    always_ff @(posedge sys_clk_i)
    begin
        if (!nrst_i)
        begin
            state_q <= '0;
            state_q.global_irq_enable <= RST_INTERRUPT_CONTROL[BIT_GLOBAL_IRQ_ENABLE];
            state_q.peripheral_group_enable
                <= RST_INTERRUPT_CONTROL[BIT_PERIPHERAL_GROUP_ENABLE];
            state_q.timer0_overflow_enable
                <= RST_INTERRUPT_CONTROL[BIT_TIMER0_OVERFLOW_ENABLE];
            state_q.ext_pin_irq_enable <= RST_INTERRUPT_CONTROL[BIT_EXT_PIN_IRQ_ENABLE];
            state_q.port_change_enable <= RST_INTERRUPT_CONTROL[BIT_PORT_CHANGE_ENABLE];
            state_q.peripheral_irq_enable_1 <= RST_PERIPHERAL_IRQ_ENABLE_1;
            state_q.edge_rising <= RST_EDGE_RISING;
            state_q.pin_change_config <= RST_PIN_CHANGE_CONFIG[PORT_PINS-1:0];
            state_q.rsp.prdata <= RST_PRDATA;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign apb_o = state_q.rsp;
    assign irq_o = state_q.irq;

endmodule

`default_nettype wire

// ===== verif/event_source_model.sv
`timescale 1ns/1ps
`default_nettype none
module event_source_model
    import irq_pkg::*;
(
    // Clock
    input wire logic sys_clk_i,
    // Event lines
    output logic timer0_overflow_o,
    output logic ext_pin_o,
    output logic [PORT_W-1:0] port_o,
    output logic [REG_W-1:0] pflags_o
);
    logic [7:0] timer0_count = 8'h00;
    initial
    begin
        timer0_overflow_o = 1'b0;
        ext_pin_o = 1'b0;
        port_o = '0;
        pflags_o = '0;
    end
    // Count from a preset; reset never touches it
    task automatic run_timer0(input logic [7:0] start, input int n);
        timer0_count = start;
        repeat (n)
        begin
            @(posedge sys_clk_i);
            timer0_count <= timer0_count + 8'h01;
            timer0_overflow_o <= timer0_count == 8'hFF;
        end
        @(posedge sys_clk_i);
        timer0_overflow_o <= 1'b0;
    endtask
    task automatic drive(input logic pin, input logic [7:0] port, input logic [7:0] pf);
        @(posedge sys_clk_i);
        ext_pin_o <= pin;
        port_o <= port;
        pflags_o <= pf;
    endtask
endmodule
`default_nettype wire

// ===== verif/irq_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module irq_asserts
    import irq_pkg::*;
(
    // Watched ports
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire apb_req_t apb_i,
    input wire apb_rsp_t apb_o,
    input wire logic timer0_overflow_i,
    input wire logic [REG_W-1:0] periph_flags_i,
    input wire logic irq_o
);
    logic [7:0] ctl_q;
    logic [7:0] pie_q;
    logic wr;
    logic ok_addr;
    assign wr = apb_i.psel && apb_i.penable && apb_o.pready && apb_i.pwrite;
    assign ok_addr = apb_i.paddr[1:0] == 2'b00 && apb_i.paddr <= OFS_PERIPH_FLAG_STATUS;
    // ==========
    // Shadow of the enables; only bus writes move them
    always_ff @(posedge sys_clk_i)
    begin
        if (!nrst_i)
        begin
            ctl_q <= 8'h00;
            pie_q <= 8'h00;
        end
        else if (wr && apb_i.paddr == OFS_INTERRUPT_CONTROL)
            ctl_q <= apb_i.pwdata[7:0];
        else if (wr && apb_i.paddr == OFS_PERIPHERAL_IRQ_ENABLE_1)
            pie_q <= apb_i.pwdata[7:0];
    end
    // ==========
    // Properties
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!nrst_i);
    sequence setup_s;
        apb_i.psel && !apb_i.penable;
    endsequence
    sequence rd_s(logic [ADDR_W-1:0] a);
        setup_s ##0 (!apb_i.pwrite && apb_i.paddr == a);
    endsequence
    setup_answer_a: assert property (setup_s |=> apb_o.pready && apb_o.pslverr == !$past(ok_addr))
        else $error("bus answer late or error flag wrong");
    answer_once_a: assert property (apb_o.pready |=> !apb_o.pready)
        else $error("ready held beyond one cycle");
    err_zero_a: assert property (apb_o.pslverr |-> apb_o.prdata == 32'h0000_0000)
        else $error("read data not zero on error");
    ctl_read_a: assert property (rd_s(OFS_INTERRUPT_CONTROL) |=>
        apb_o.prdata[7:3] == $past(ctl_q[7:3])) else $error("control enables read wrong");
    pie_read_a: assert property (rd_s(OFS_PERIPHERAL_IRQ_ENABLE_1) |=>
        apb_o.prdata == {24'h00_0000, $past(pie_q)}) else $error("peripheral enables read wrong");
    reset_quiet_a: assert property ($rose(nrst_i) |-> !irq_o && !apb_o.pready)
        else $error("outputs active after reset");
    irq_cause_a: assert property (irq_o |-> $past(ctl_q[7]) && ($past(|ctl_q[5:3])
        || $past(ctl_q[6]) && $past(|(pie_q & periph_flags_i)))) else $error("request uncaused");
    irq_periph_a: assert property (ctl_q[7] && ctl_q[6] && |(pie_q & periph_flags_i)
        |=> irq_o) else $error("peripheral request lost");
    timer0_irq_a: assert property (timer0_overflow_i ##1 (ctl_q[7] && ctl_q[5])
        |=> irq_o) else $error("timer0 request lost");
endmodule
`default_nettype wire

// ===== verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
    import irq_pkg::*;
;
    logic sys_clk_i;
    logic nrst_i;
    apb_req_t apb_i;
    apb_rsp_t apb_o;
    logic t0, pin, irq, err;
    logic [7:0] port, pf, c, p, f;
    logic [15:0] seed = 16'h599C;
    logic [31:0] rd;
    int n_errors = 0;
    int num_checks = 0;
    core_interrupt_enable_logic uut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .apb_i(apb_i),
        .apb_o(apb_o), .timer0_overflow_i(t0), .external_irq_pin_i(pin),
        .general_port_i(port), .periph_flags_i(pf), .irq_o(irq));
    event_source_model src (.sys_clk_i(sys_clk_i), .timer0_overflow_o(t0), .ext_pin_o(pin),
        .port_o(port), .pflags_o(pf));
    initial
    begin
        sys_clk_i = 1'b0;
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end
    // ==========
    // Helpers
    function automatic logic [7:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed[7:0];
    endfunction
    function automatic logic exp_irq(input logic [7:0] c, input logic [7:0] p, input logic [7:0] f);
        return c[7] && (|(c[5:3] & c[2:0]) || c[6] && |(p & f));
    endfunction
    task automatic conclude();
        $display("checks=%0d errors=%0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int k;
        @(posedge sys_clk_i);
        apb_i <= '{1'b1, 1'b0, w, a, {24'h00_0000, d}};
        @(posedge sys_clk_i);
        apb_i.penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge sys_clk_i);
            k++;
        end
        while (apb_o.pready !== 1'b1 && k < 20);
        if (k == 20)
        begin
            n_errors++;
            conclude();
        end
        rd = apb_o.prdata;
        err = apb_o.pslverr;
        apb_i.psel <= 1'b0;
        apb_i.penable <= 1'b0;
    endtask
    task automatic irq_is(input logic e);
        repeat (2) @(posedge sys_clk_i);
        cmp({31'h0000_0000, irq}, {31'h0000_0000, e});
    endtask
    // ==========
    // Sequence
    initial
    begin
        nrst_i = 1'b0;
        apb_i = '0;
        repeat (6) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b0, 12'(4 * i), 8'h00);
            cmp(rd, {31'h0000_0000, i == 2});
        end
        apb(1'b1, 12'hFFC, 8'hFF);
        cmp({rd[30:0], err}, 32'h0000_0001);
        $display("reset and map test done");
        for (int i = 0; i < 40; i++)
        begin
            c = rnd();
            p = rnd();
            f = rnd();
            if (i < 16)
            begin
                p = 8'h01 << i[2:0];
                f = p;
                c = i < 8 ? 8'hC0 : 8'h80;
            end
            src.drive(1'b0, 8'h00, f);
            apb(1'b1, OFS_INTERRUPT_CONTROL, c);
            apb(1'b1, OFS_PERIPHERAL_IRQ_ENABLE_1, p);
            apb(1'b1, OFS_PERIPH_FLAG_STATUS, rnd());
            apb(1'b0, OFS_INTERRUPT_CONTROL, 8'h00);
            cmp(rd, {24'h00_0000, c});
            apb(1'b0, OFS_PERIPHERAL_IRQ_ENABLE_1, 8'h00);
            cmp(rd, {24'h00_0000, p});
            apb(1'b0, OFS_PERIPH_FLAG_STATUS, 8'h00);
            cmp(rd, {24'h00_0000, f});
            irq_is(exp_irq(c, p, f));
        end
        $display("gating test done");
        apb(1'b1, OFS_INTERRUPT_CONTROL, 8'h00);
        src.run_timer0(8'hFD, 4);
        apb(1'b0, OFS_INTERRUPT_CONTROL, 8'h00);
        cmp(rd, 32'h0000_0004);
        irq_is(1'b0);
        apb(1'b1, OFS_INTERRUPT_CONTROL, 8'hA0);
        src.run_timer0(8'hFF, 1);
        irq_is(1'b1);
        apb(1'b1, OFS_INTERRUPT_CONTROL, 8'h24);
        irq_is(1'b0);
        apb(1'b0, OFS_INTERRUPT_CONTROL, 8'h00);
        cmp(rd, 32'h0000_0024);
        $display("timer0 test done");
        for (int e = 1; e >= 0; e--)
        begin
            apb(1'b1, OFS_EDGE_CONFIG, {7'h00, e[0]});
            apb(1'b1, OFS_INTERRUPT_CONTROL, 8'h90);
            src.drive(e[0], 8'h00, 8'h00);
            repeat (5) @(posedge sys_clk_i);
            apb(1'b0, OFS_INTERRUPT_CONTROL, 8'h00);
            cmp(rd, 32'h0000_0092);
            irq_is(1'b1);
        end
        $display("pin edge test done");
        apb(1'b1, OFS_PIN_CHANGE_CONFIG, 8'h01);
        apb(1'b1, OFS_INTERRUPT_CONTROL, 8'h88);
        for (int k = 2; k < 4; k++)
        begin
            src.drive(1'b0, 8'(k), 8'h00);
            repeat (5) @(posedge sys_clk_i);
            apb(1'b0, OFS_INTERRUPT_CONTROL, 8'h00);
            cmp(rd, {31'h0000_0044, k == 3});
        end
        irq_is(1'b1);
        $display("port change test done");
        apb(1'b1, OFS_PERIPHERAL_IRQ_ENABLE_1, 8'hFF);
        @(posedge sys_clk_i);
        nrst_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        apb(1'b0, OFS_INTERRUPT_CONTROL, 8'h00);
        cmp(rd, 32'h0000_0000);
        apb(1'b0, OFS_PERIPHERAL_IRQ_ENABLE_1, 8'h00);
        cmp(rd, 32'h0000_0000);
        $display("second reset test done");
        conclude();
    end
endmodule
bind core_interrupt_enable_logic irq_asserts chk (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .apb_i(apb_i), .apb_o(apb_o), .timer0_overflow_i(timer0_overflow_i),
    .periph_flags_i(periph_flags_i), .irq_o(irq_o));
`default_nettype wire
